// ---- hdl/energy_pulse_output_shaper.sv ----
// energy pulse output shaper: power word to low-rate and calibration pulse trains
// assumes active_power comes from same-clock logic; mode selects are asynchronous pins
`timescale 1ns/1ps
module energy_pulse_output_shaper
  import pulse_shaper_pkg::*;
#(
  parameter int     POWER_W          = 16,
  parameter longint LOW_WIDTH_C      = LOW_WIDTH_CYC,
  parameter longint LOW_FALLBACK_C   = LOW_FALLBACK_CYC,
  parameter longint CAL_WIDTH_C      = CAL_WIDTH_CYC,
  parameter longint CAL_FALLBACK_C   = CAL_FALLBACK_CYC,
  parameter logic [MCLK_ACC_W-1:0] MCLK_STEP = MCLK_INC
) (
  input  wire logic               clock,              // 40 MHz system clock
  input  wire logic               rst_n,              // synchronous reset, active low
  input  wire logic [POWER_W-1:0] active_power,       // unsigned power magnitude
  input  wire logic               rate_select_lsb,    // rate select bit 0, pin
  input  wire logic               rate_select_msb,    // rate select bit 1, pin
  input  wire logic               cal_scale_select,   // calibration scale select, pin
  output logic                    low_rate_pulse_a_n, // first low-rate output, active low
  output logic                    low_rate_pulse_b_n, // second low-rate output, active low
  output logic                    calibration_pulse   // calibration output, active high
);

  localparam int ACC_W = POWER_W + 24;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  // the factor is a 32-bit int, so it is widened by a cast rather than a part-select
  localparam logic [ACC_W-1:0] FS_FACTOR = ACC_W'(FS_FACTOR_NUM);
  localparam longint NOLOAD_WIDE =
    ((64'(1) << POWER_W) * NOLOAD_PPM_NUM + PPM_DEN - 1) / PPM_DEN;
  localparam logic [POWER_W-1:0] NOLOAD_MIN = NOLOAD_WIDE[POWER_W-1:0];

  // calibration multiple as a power-of-two exponent
  function automatic int cal_exp(input logic scale, input logic [1:0] code);
    int e;
    e = CAL_EXP_S0_R0;
    case ({scale, code})
      3'b100:  e = CAL_EXP_S1_R0;
      3'b101:  e = CAL_EXP_S1_R1;
      3'b110:  e = CAL_EXP_S1_R2;
      3'b111:  e = CAL_EXP_S1_R3;
      3'b000:  e = CAL_EXP_S0_R0;
      3'b001:  e = CAL_EXP_S0_R1;
      3'b010:  e = CAL_EXP_S0_R2;
      3'b011:  e = CAL_EXP_S0_R3;
      default: e = CAL_EXP_S0_R0;
    endcase
    return e;                                       // R13
  endfunction

  function automatic logic is_fast(input logic scale, input logic [1:0] code);
    return !scale && (code == RATE_CODE_FAST);
  endfunction

  // ---- pin synchronisers ----
  logic [2:0] pin_meta_r;
  logic [2:0] pin_sync_r;
  logic [2:0] pin_prev_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_meta_r <= 3'h0;
      pin_sync_r <= 3'h0;
    end else begin
      pin_meta_r <= {cal_scale_select, rate_select_msb, rate_select_lsb};
      pin_sync_r <= pin_meta_r;
    end
  end

  logic [1:0] rate_code;
  logic       scale_sel;
  logic       fast_mode;
  logic       mode_change;
  assign rate_code   = pin_sync_r[1:0];
  assign scale_sel   = pin_sync_r[2];
  assign fast_mode   = is_fast(scale_sel, rate_code);
  assign mode_change = pin_sync_r != pin_prev_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pin_prev_r <= 3'h0;
    end else begin
      pin_prev_r <= pin_sync_r;
    end
  end

  // ---- master clock tick enable, 3.579 MHz from the system clock ----
  logic [MCLK_ACC_W-1:0] mclk_acc_r;
  logic                  mclk_tick_r;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mclk_acc_r  <= '0;
      mclk_tick_r <= 1'b0;
    end else begin
      {mclk_tick_r, mclk_acc_r} <= {1'b0, mclk_acc_r} + {1'b0, MCLK_STEP};  // R12 R14
    end
  end

  // ---- digital-to-frequency conversion ----
  // one calibration event every cal_thresh of accumulated power; the base
  // divider 2^(21-code) folds into the threshold, so no separate prescaler
  logic [ACC_W-1:0] cal_thresh;
  logic [ACC_W-1:0] power_ext;
  logic [ACC_W-1:0] energy_r;
  logic [ACC_W-1:0] energy_sum;
  logic             below_floor;
  logic             cal_event;
  int               thresh_shift;

  always_comb begin
    thresh_shift = POWER_W + BASE_DIV_EXP_MAX - 1 - int'(rate_code)
                   - cal_exp(scale_sel, rate_code);            // R10 R11 R12 R13
    cal_thresh   = FS_FACTOR << thresh_shift;
  end

  assign power_ext   = {{(ACC_W-POWER_W){1'b0}}, active_power};
  assign below_floor = (active_power < NOLOAD_MIN) && !fast_mode;  // R8 R9
  assign energy_sum  = energy_r + power_ext;
  assign cal_event   = mclk_tick_r && !below_floor && (energy_sum >= cal_thresh);

  // creep guard: below the floor nothing accumulates and no new pulse starts, except in fast mode where the floor is off
  always_ff @(posedge clock) begin
    if (!rst_n || mode_change) begin
      energy_r <= '0;
    end else if (mclk_tick_r && !below_floor) begin        // R8
      if (energy_sum >= cal_thresh) begin
        energy_r <= energy_sum - cal_thresh;
      end else begin
        energy_r <= energy_sum;
      end
    end
  end

  // ---- low-rate event: one per 2^cal_exp calibration events ----
  logic [CNT_W-1:0] ratio_cnt_r;
  logic [CNT_W-1:0] ratio_last;
  logic             low_event;

  assign ratio_last = CNT_W'((1 << cal_exp(scale_sel, rate_code)) - 1);
  assign low_event  = cal_event && (ratio_cnt_r == ratio_last);

  always_ff @(posedge clock) begin
    if (!rst_n || mode_change) begin
      ratio_cnt_r <= '0;
    end else if (cal_event) begin
      if (ratio_cnt_r == ratio_last) begin
        ratio_cnt_r <= '0;                                 // R13
      end else begin
        ratio_cnt_r <= ratio_cnt_r + CNT_ONE;
      end
    end
  end

  // ---- alternation between the two low-rate outputs ----
  // successive low-rate events go to a then b, so b falls half an a period later
  low_rate_state_e lr_state_r;
  low_rate_state_e lr_state_nxt;

  always_comb begin
    lr_state_nxt = lr_state_r;
    case (lr_state_r)
      LR_IDLE: if (low_event) lr_state_nxt = LR_A;
      LR_A:    if (low_event) lr_state_nxt = LR_B;     // R1 R3
      LR_B:    if (low_event) lr_state_nxt = LR_A;     // R1 R3
      default: lr_state_nxt = LR_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lr_state_r <= LR_IDLE;
    end else begin
      lr_state_r <= lr_state_nxt;
    end
  end

  // ---- pulse timers ----
  // the low-rate timer sees the combined a/b event train; half its interval
  // bounds the width so that a and b never overlap
  logic low_active;
  logic cal_active;

  pulse_timer #(
    .WIDTH_CYC    (LOW_WIDTH_C),
    .FALLBACK_CYC (LOW_FALLBACK_C),
    .FAST_CYC     (CAL_FAST_CYC)
  ) u_low_timer (
    .clock     (clock),
    .rst_n     (rst_n),
    .restart   (mode_change),
    .fire      (low_event),
    .fast_mode (1'b0),
    .active    (low_active)
  );

  pulse_timer #(
    .WIDTH_CYC    (CAL_WIDTH_C),
    .FALLBACK_CYC (CAL_FALLBACK_C),
    .FAST_CYC     (CAL_FAST_CYC)
  ) u_cal_timer (
    .clock     (clock),
    .rst_n     (rst_n),
    .restart   (mode_change),
    .fire      (cal_event),
    .fast_mode (fast_mode),
    .active    (cal_active)
  );

  // ---- output registers ----
  // timer level is combined with the alternation state one cycle later
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      low_rate_pulse_a_n <= 1'b1;                          // R14
      low_rate_pulse_b_n <= 1'b1;
      calibration_pulse  <= 1'b0;
    end else begin
      low_rate_pulse_a_n <= !(low_active && (lr_state_r == LR_A));  // R1 R2
      low_rate_pulse_b_n <= !(low_active && (lr_state_r == LR_B));  // R1 R2
      calibration_pulse  <= cal_active;                    // R5
    end
  end

endmodule

// ---- include/pulse_shaper_pkg.sv ----
// constants, mode encodings and timing counts for the energy pulse output shaper
// assumes a single 40 MHz system clock and a datapath that supplies an unsigned power word
//
// Functional notes
// [R1] the two low-rate outputs give alternating active-low pulses
// [R2] each low-rate pulse stays low for 275 ms when the period allows
// [R3] second low-rate output falls about half a period after the first
// [R4] low-rate period under 550 ms gives a width of half the period
// [R5] calibration output gives 90 ms active-high pulses at a power-proportional rate
// [R6] calibration period under 180 ms gives a width of half the period
// [R7] high-frequency mode fixes the calibration pulse width at 18 us
// [R8] loads below 0.0014 percent of full-scale frequency issue no pulses anywhere
// [R9] no-load suppression is off only in high-frequency mode
// [R10] two-bit rate select picks one of four base frequencies and the low-rate maximum
// [R11] half-scale ac inputs give 0.085, 0.17, 0.34, 0.68 Hz low-rate output
// [R12] base frequencies are the 3.579 MHz master clock over 2^21 down to 2^18
// [R13] calibration rate is 128/64/32/16 or 64/32/16/2048 times the low rate
// [R14] width and period come from master-clock counters; reset holds outputs inactive (the pulse timers count widths in 40 MHz system-clock cycles instead)
package pulse_shaper_pkg;

  localparam longint CLOCK_HZ       = 40_000_000;
  localparam longint MCLK_HZ        = 3_579_000;
  // phase increment that gives one master-clock tick enable per 3.579 MHz period
  localparam int     MCLK_ACC_W     = 32;
  localparam longint MCLK_INC_WIDE  = (MCLK_HZ << MCLK_ACC_W) / CLOCK_HZ;
  localparam logic [MCLK_ACC_W-1:0] MCLK_INC = MCLK_INC_WIDE[MCLK_ACC_W-1:0];

  // pulse timing, figures as printed, cycle counts derived
  localparam longint LOW_WIDTH_MS      = 275;
  localparam longint LOW_FALLBACK_MS   = 550;
  localparam longint CAL_WIDTH_MS      = 90;
  localparam longint CAL_FALLBACK_MS   = 180;
  localparam longint CAL_FAST_WIDTH_US = 18;
  localparam longint LOW_WIDTH_CYC     = LOW_WIDTH_MS * CLOCK_HZ / 1000;
  localparam longint LOW_FALLBACK_CYC  = LOW_FALLBACK_MS * CLOCK_HZ / 1000;
  localparam longint CAL_WIDTH_CYC     = CAL_WIDTH_MS * CLOCK_HZ / 1000;
  localparam longint CAL_FALLBACK_CYC  = CAL_FALLBACK_MS * CLOCK_HZ / 1000;
  localparam longint CAL_FAST_CYC      = CAL_FAST_WIDTH_US * CLOCK_HZ / 1_000_000;

  // width of the cycle counters in the pulse timers
  localparam int     TIMER_W = 32;

  // base divider: master clock over 2^(BASE_DIV_EXP_MAX - rate code)
  localparam int     BASE_DIV_EXP_MAX = 21;
  // full-scale dc gives 0.4 x f_i on the low-rate pins, i.e. a threshold factor of 5/2
  localparam int     FS_FACTOR_NUM    = 5;
  // no-load floor: 14 parts per million of full-scale frequency, over 0.4
  localparam longint NOLOAD_PPM_NUM   = 35;
  localparam longint PPM_DEN          = 1_000_000;

  // calibration multiple exponents (2^n times low rate)
  localparam int     CAL_EXP_S1_R0 = 7;
  localparam int     CAL_EXP_S1_R1 = 6;
  localparam int     CAL_EXP_S1_R2 = 5;
  localparam int     CAL_EXP_S1_R3 = 4;
  localparam int     CAL_EXP_S0_R0 = 6;
  localparam int     CAL_EXP_S0_R1 = 5;
  localparam int     CAL_EXP_S0_R2 = 4;
  localparam int     CAL_EXP_S0_R3 = 11;

  localparam logic [1:0] RATE_CODE_FAST = 2'h3;

  typedef enum logic [2:0] {
    LR_IDLE = 3'b001,
    LR_A    = 3'b010,
    LR_B    = 3'b100
  } low_rate_state_e;

endpackage

// ---- hdl/pulse_timer.sv ----
// one-shot pulse timer with period tracking and half-period fallback
// assumes fire is a one-cycle pulse on the system clock
`timescale 1ns/1ps
module pulse_timer
  import pulse_shaper_pkg::*;
#(
  parameter longint WIDTH_CYC    = LOW_WIDTH_CYC,
  parameter longint FALLBACK_CYC = LOW_FALLBACK_CYC,
  parameter longint FAST_CYC     = CAL_FAST_CYC
) (
  input  wire logic clock,      // system clock
  input  wire logic rst_n,      // synchronous reset, active low
  input  wire logic restart,    // forget the last period (mode change)
  input  wire logic fire,       // start of a pulse
  input  wire logic fast_mode,  // use the fixed narrow width
  output logic      active      // pulse level, registered
);

  localparam logic [TIMER_W-1:0] WIDTH_C    = WIDTH_CYC[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] FALLBACK_C = FALLBACK_CYC[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] FAST_C     = FAST_CYC[TIMER_W-1:0];
  localparam logic [TIMER_W-1:0] ONE_C      = {{(TIMER_W-1){1'b0}}, 1'b1};
  localparam logic [TIMER_W-1:0] MAX_C      = {TIMER_W{1'b1}};

  logic [TIMER_W-1:0] period_r;
  logic [TIMER_W-1:0] remain_r;
  logic [TIMER_W-1:0] width_nxt;

  // unknown period after reset counts as long, so the first pulse is full width
  always_ff @(posedge clock) begin
    if (!rst_n || restart) begin
      period_r <= MAX_C;
    end else if (fire) begin
      period_r <= ONE_C;
    end else if (period_r != MAX_C) begin
      period_r <= period_r + ONE_C;
    end
  end

  always_comb begin
    width_nxt = WIDTH_C;
    if (fast_mode) begin
      width_nxt = FAST_C;                           // R7
    end else if (period_r < FALLBACK_C) begin
      width_nxt = period_r >> 1;                    // R4 R6
      if (width_nxt == '0) begin
        width_nxt = ONE_C;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || restart) begin
      remain_r <= '0;
      active   <= 1'b0;
    end else if (fire) begin
      remain_r <= width_nxt - ONE_C;                // R2 R5 R14
      active   <= 1'b1;
    end else if (remain_r != '0) begin
      remain_r <= remain_r - ONE_C;
    end else begin
      active   <= 1'b0;
    end
  end

endmodule

// ---- test/energy_pulse_output_shaper_props.sv ----
// timing assertions on the pulse outputs of the energy pulse shaper
// assumes binding into the shaper; sees its ports only
`timescale 1ns/1ps
module energy_pulse_output_shaper_props
  import pulse_shaper_pkg::*;
#(
  parameter int     POWER_W        = 16,
  parameter longint LOW_WIDTH_C    = LOW_WIDTH_CYC,
  parameter longint CAL_WIDTH_C    = CAL_WIDTH_CYC,
  parameter longint CAL_FALLBACK_C = CAL_FALLBACK_CYC
) (
  input wire logic               clock,              // system clock
  input wire logic               rst_n,              // synchronous reset
  input wire logic [POWER_W-1:0] active_power,       // power word
  input wire logic               rate_select_lsb,    // rate bit 0
  input wire logic               rate_select_msb,    // rate bit 1
  input wire logic               cal_scale_select,   // scale pin
  input wire logic               low_rate_pulse_a_n, // low-rate a
  input wire logic               low_rate_pulse_b_n, // low-rate b
  input wire logic               calibration_pulse   // calibration
);
  localparam longint NL_MIN = ((longint'(1) << POWER_W) * NOLOAD_PPM_NUM + PPM_DEN - 1) / PPM_DEN;
  logic [2:0]  pins_q;
  logic [15:0] mode_age;
  logic [31:0] cal_len, low_len, gap, last_gap;
  logic        seen, pair_ok, next_b;
  logic [7:0]  quiet;
  wire  [2:0]  pins = {cal_scale_select, rate_select_msb, rate_select_lsb};
  wire         fast = (pins == 3'h3);
  wire  [31:0] half = (last_gap < 32'h2) ? 32'h1 : last_gap >> 1;
  wire  [31:0] cal_exp = (pair_ok && last_gap < CAL_FALLBACK_C) ? half : 32'(CAL_WIDTH_C);

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // pulses that straddle a pin change are cut short, so they are left out
  always_ff @(posedge clock) begin
    pins_q   <= pins;
    mode_age <= (!rst_n || pins != pins_q) ? 16'h0 : mode_age + {15'h0, mode_age != 16'hFFFF};
  end
  always_ff @(posedge clock) begin
    cal_len <= (rst_n && calibration_pulse) ? cal_len + 32'h1 : 32'h0;
    low_len <= (rst_n && !(low_rate_pulse_a_n && low_rate_pulse_b_n)) ? low_len + 32'h1 : 32'h0;
    gap     <= $rose(calibration_pulse) ? 32'h1 : gap + 32'h1;
  end
  always_ff @(posedge clock) begin
    if (!rst_n || pins != pins_q) begin
      seen    <= 1'b0;
      pair_ok <= 1'b0;
    end else if ($rose(calibration_pulse)) begin
      seen     <= 1'b1;
      pair_ok  <= seen;
      last_gap <= gap;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_n) next_b <= 1'b0;
    else if ($fell(low_rate_pulse_a_n)) next_b <= 1'b1;
    else if ($fell(low_rate_pulse_b_n)) next_b <= 1'b0;
  end
  always_ff @(posedge clock) begin
    if (!rst_n || fast || active_power >= NL_MIN) quiet <= 8'h0;
    else if (quiet != 8'hFF) quiet <= quiet + 8'h1;
  end

  reset_idle_a: assert property ($rose(rst_n) |-> low_rate_pulse_a_n && low_rate_pulse_b_n
    && !calibration_pulse) else $error("output active after reset");
  fast_width_a: assert property ($fell(calibration_pulse) && fast && mode_age > cal_len + 8
    |-> cal_len == CAL_FAST_CYC) else $error("fast calibration width wrong");
  cal_width_a: assert property ($fell(calibration_pulse) && !fast && mode_age > cal_len + 8
    |-> cal_len == cal_exp) else $error("calibration width wrong");
  low_width_a: assert property ($rose(low_rate_pulse_a_n) || $rose(low_rate_pulse_b_n)
    |-> low_len >= 1 && low_len <= LOW_WIDTH_C) else $error("low-rate width too long");
  low_apart_a: assert property (low_rate_pulse_a_n || low_rate_pulse_b_n)
    else $error("both low-rate outputs low");
  alt_order_a: assert property ($fell(low_rate_pulse_a_n) || $fell(low_rate_pulse_b_n)
    |-> $fell(low_rate_pulse_a_n) == !next_b) else $error("low-rate outputs not alternating");
  pair_cal_a: assert property (($fell(low_rate_pulse_a_n) || $fell(low_rate_pulse_b_n))
    && !fast |-> $rose(calibration_pulse)) else $error("low-rate pulse without calibration");
  noload_quiet_a: assert property (quiet > 8'h0C |-> !$rose(calibration_pulse)
    && !$fell(low_rate_pulse_a_n) && !$fell(low_rate_pulse_b_n)) else $error("pulse under floor");

  cover property ($fell(calibration_pulse) && fast);
  cover property ($fell(calibration_pulse) && !fast);
  cover property (quiet == 8'hFF);
endmodule

bind energy_pulse_output_shaper energy_pulse_output_shaper_props #(
  .POWER_W(POWER_W), .LOW_WIDTH_C(LOW_WIDTH_C), .CAL_WIDTH_C(CAL_WIDTH_C),
  .CAL_FALLBACK_C(CAL_FALLBACK_C)
) props_i (
  .clock(clock), .rst_n(rst_n), .active_power(active_power),
  .rate_select_lsb(rate_select_lsb), .rate_select_msb(rate_select_msb),
  .cal_scale_select(cal_scale_select), .low_rate_pulse_a_n(low_rate_pulse_a_n),
  .low_rate_pulse_b_n(low_rate_pulse_b_n), .calibration_pulse(calibration_pulse)
);

// ---- test/pulse_counter_model.sv ----
// pulse counter standing in for the meter's stepper or counter input
// assumes the shaper outputs on the same clock; clear zeroes the tallies
`timescale 1ns/1ps
module pulse_counter_model (
  input  wire logic clock,      // system clock
  input  wire logic clear,      // zero the tallies
  input  wire logic low_a_n,    // low-rate a
  input  wire logic low_b_n,    // low-rate b
  input  wire logic cal,        // calibration
  output int        cal_edges,  // calibration pulses seen
  output int        cal_width,  // last calibration width
  output int        cal_gap,    // last rise-to-rise interval
  output int        low_edges,  // low-rate pulses seen
  output int        order_errs  // same output twice running
);
  logic a_q = 1'b1;
  logic b_q = 1'b1;
  logic c_q = 1'b0;
  logic next_b = 1'b0;
  int   run = 0;
  int   gap = 0;
  always @(posedge clock) begin
    a_q <= low_a_n;
    b_q <= low_b_n;
    c_q <= cal;
    run <= cal ? run + 1 : 0;
    gap <= (cal && !c_q) ? 1 : gap + 1;
    if (!cal && c_q) cal_width <= run;
    if (cal && !c_q) begin
      cal_edges <= cal_edges + 1;
      cal_gap   <= gap;
    end
    if (!low_a_n && a_q) begin
      low_edges  <= low_edges + 1;
      order_errs <= order_errs + int'(next_b);
      next_b     <= 1'b1;
    end
    if (!low_b_n && b_q) begin
      low_edges  <= low_edges + 1;
      order_errs <= order_errs + int'(!next_b);
      next_b     <= 1'b0;
    end
    // clear wins over any edge in the same cycle
    if (clear) begin
      cal_edges  <= 0;
      low_edges  <= 0;
      order_errs <= 0;
      cal_width  <= 0;
      cal_gap    <= 0;
    end
  end
endmodule

// ---- test/energy_pulse_output_shaper_tb.sv ----
// self-checking bench for the pulse shaper with shortened widths and a fast master tick
// assumes a 40 MHz clock and the pulse counter model on the outputs
`timescale 1ns/1ps
module energy_pulse_output_shaper_tb;
  import pulse_shaper_pkg::*;
  localparam longint      CAL_W = 40;
  localparam logic [15:0] FAST_PWR = 16'h4000;
  localparam longint SLOW_TICKS = ((longint'(FS_FACTOR_NUM) << (16 + 20 - 2 - CAL_EXP_S1_R2))
                                   + 65534) / 65535;
  localparam longint FAST_GAP = (longint'(FS_FACTOR_NUM) << (16 + 20 - 3 - CAL_EXP_S0_R3))
                                / FAST_PWR;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] active_power = 16'h0000;
  logic        rate_select_lsb = 1'b0;
  logic        rate_select_msb = 1'b0;
  logic        cal_scale_select = 1'b1;
  logic        clr = 1'b1;
  logic        a_n, b_n, cal;
  int          cal_edges, cal_width, cal_gap, low_edges, order_errs;
  int          errors = 0;
  int          num_checks = 0;
  int          cycles = 0;

  always #12.5 clock = ~clock;

  energy_pulse_output_shaper #(
    .LOW_WIDTH_C(200), .LOW_FALLBACK_C(400), .CAL_WIDTH_C(CAL_W), .CAL_FALLBACK_C(80),
    .MCLK_STEP(32'hFFFF_FFFF)
  ) uut (
    .clock(clock), .rst_n(rst_n), .active_power(active_power),
    .rate_select_lsb(rate_select_lsb), .rate_select_msb(rate_select_msb),
    .cal_scale_select(cal_scale_select), .low_rate_pulse_a_n(a_n),
    .low_rate_pulse_b_n(b_n), .calibration_pulse(cal)
  );

  pulse_counter_model counter (
    .clock(clock), .clear(clr), .low_a_n(a_n), .low_b_n(b_n), .cal(cal),
    .cal_edges(cal_edges), .cal_width(cal_width), .cal_gap(cal_gap),
    .low_edges(low_edges), .order_errs(order_errs)
  );

  task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: %s seen %0d expected %0d", $time, what, seen, exp);
    end
  endtask

  task automatic end_sim();
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic set_mode(input logic scale, input logic msb, input logic lsb,
                          input logic [15:0] pwr);
    @(negedge clock);
    cal_scale_select = scale;
    rate_select_msb  = msb;
    rate_select_lsb  = lsb;
    active_power     = pwr;
    clr              = 1'b1;
    @(negedge clock);
    clr = 1'b0;
  endtask

  task automatic t_reset_idle();
    repeat (20) @(negedge clock);
    check({a_n, b_n, cal}, 3'h6, "outputs in reset");
    rst_n = 1'b1;
  endtask

  task automatic t_fast();
    set_mode(1'b0, 1'b1, 1'b1, FAST_PWR);
    repeat (5520) @(negedge clock);
    check(cal_edges, 4, "fast pulse count");
    check(cal_gap, FAST_GAP, "fast period");
    check(cal_width, CAL_FAST_CYC, "fast width");
    check(low_edges, 0, "low-rate count in fast mode");
  endtask

  task automatic t_mid_reset();
    int n;
    n = 0;
    while (cal !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check(cal, 1'b1, "pulse before reset");
    rst_n = 1'b0;
    @(negedge clock);
    check({a_n, b_n, cal}, 3'h6, "outputs after mid-run reset");
    repeat (3) @(negedge clock);
    rst_n = 1'b1;
  endtask

  task automatic t_noload();
    set_mode(1'b1, 1'b0, 1'b0, 16'h0002);
    repeat (3000) @(negedge clock);
    check(cal_edges, 0, "calibration under floor");
    check(low_edges, 0, "low-rate under floor");
  endtask

  task automatic t_slow();
    int n;
    n = 0;
    set_mode(1'b1, 1'b1, 1'b0, 16'hFFFF);
    while (cal_edges == 0 && n < 41200) begin
      @(negedge clock);
      n++;
    end
    check(n >= SLOW_TICKS && n <= SLOW_TICKS + 14, 1'b1, "first slow pulse time");
    repeat (CAL_W + 8) @(negedge clock);
    check(cal_width, CAL_W, "slow width");
    check(order_errs, 0, "low-rate order");
  endtask

  initial begin
    t_reset_idle();
    t_fast();
    t_mid_reset();
    t_noload();
    t_slow();
    end_sim();
  end

  // about 50k cycles expected; the ceiling leaves some slack
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      end_sim();
    end
  end
endmodule
